// File: rtl/irc_remote_ctrl.sv
// remote control, trigger, calibration and status logic of a bench supply
// Function
// [RULE_01] go-local command enters local mode, enabling all panel knobs.
// [RULE_02] go-remote enters remote mode; only the local key stays enabled.
// [RULE_03] host sends go-remote before other commands on the serial link.
// [RULE_04] lockout is remote with the local key disabled too.
// [RULE_05] display off blanks annunciators except error; state is readable. The code blanks all of them, error included, via annunciators_en.
// [RULE_06] display switches back on on every return to local mode.
// [RULE_07] message write shows text, query returns it, erase removes it.
// [RULE_08] brightness accepts levels 0 to 4, dark to bright.
// [RULE_09] trigger source holds bus or immediate; query reports it.
// [RULE_10] trigger wait holds 0 to 3600 s; min picks 0, max 3600.
// [RULE_11] wait applies only with bus source, ignored for immediate.
// [RULE_12] immediate source: arm applies triggered levels at once.
// [RULE_13] bus source and armed: levels applied after bus trigger.
// [RULE_14] host selects source, then delay, then arms.
// [RULE_15] calibration entered only with correct password; others need it.
// [RULE_16] cal kind: voltage 0, ovp 1, current 2, ocp 3.
// [RULE_17] after min, mid, max voltage points kind advances to 1.
// [RULE_18] commit stores values and exits; abort exits and discards.
// [RULE_19] each status group has 16-bit condition, event, enable.
// [RULE_20] condition bits follow their inputs live, unlatched.
// [RULE_21] event bit latches on rising condition, then ignores it.
// [RULE_22] event bit stays until event read or clear-status.
// [RULE_23] enabled events reach the summary; summary raises service request.
// [RULE_24] summary is OR over bits of event AND enable.
// [RULE_25] edges found against last cycle's condition value.
`include "irc_defines.svh"
module irc_remote_ctrl
   import irc_pkg::*;
#(
   parameter int          STAT_W    = 16,
   parameter int          VAL_W     = 16,
   parameter int unsigned CLK_HZ    = `IRC_CLK_HZ,
   parameter logic [15:0] CAL_PASS  = 16'h1234  // arbitrary value
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 go_local_cmd,
   input  wire logic                 go_remote_cmd,
   input  wire logic                 remote_lockout_cmd,
   input  wire logic                 panel_display_wr,
   input  wire logic                 panel_display_val,
   input  wire logic                 panel_message_wr,
   input  wire logic [8*`IRC_MSG_CHARS-1:0] panel_message_val,
   input  wire logic                 panel_message_erase,
   input  wire logic                 panel_brightness_wr,
   input  wire logic [2:0]           panel_brightness_val,
   input  wire logic                 trig_origin_wr,
   input  wire logic                 trig_origin_imm,
   input  wire logic                 trig_wait_wr,
   input  wire logic [11:0]          trig_wait_val,
   input  wire logic                 trig_wait_min,
   input  wire logic                 trig_wait_max,
   input  wire logic                 trig_level_wr,
   input  wire logic [VAL_W-1:0]     trig_volt_val,
   input  wire logic [VAL_W-1:0]     trig_curr_val,
   input  wire logic                 arm_trigger,
   input  wire logic                 bus_trigger,
   input  wire logic                 cal_entry_key,
   input  wire logic [15:0]          cal_password,
   input  wire logic                 cal_kind_wr,
   input  wire logic [1:0]           cal_kind_val,
   input  wire logic                 cal_point_wr,
   input  wire logic [1:0]           cal_point_sel,
   input  wire logic [VAL_W-1:0]     cal_point_val,
   input  wire logic                 overvoltage_auto_trim,
   input  wire logic                 overcurrent_auto_trim,
   input  wire logic                 cal_commit_exit,
   input  wire logic                 cal_abort_exit,
   input  wire logic [STAT_W-1:0]    quality_alarm_cond_in,
   input  wire logic [STAT_W-1:0]    operation_cond_in,
   input  wire logic                 quality_alarm_mask_wr,
   input  wire logic                 operation_mask_wr,
   input  wire logic [STAT_W-1:0]    mask_wdata,
   input  wire logic                 status_preset,
   input  wire logic                 quality_alarm_latched_rd,
   input  wire logic                 operation_latched_rd,
   input  wire logic                 clear_status_cmd,
   output logic                      panel_remote,
   output logic                      panel_knobs_en,
   output logic                      panel_local_key_en,
   output logic                      panel_display_on,
   output logic                      annunciators_en,
   output logic [8*`IRC_MSG_CHARS-1:0] panel_message,
   output logic                      panel_message_shown,
   output logic [2:0]                panel_brightness,
   output logic                      trig_origin_is_imm,
   output logic [11:0]               trig_wait,
   output logic                      trig_armed,
   output logic [VAL_W-1:0]          out_volt_level,
   output logic [VAL_W-1:0]          out_curr_level,
   output logic                      out_level_apply,
   output logic                      cal_mode,
   output logic [1:0]                cal_kind,
   output logic                      cal_cmd_refused,
   output logic                      cal_store,
   output logic [4*VAL_W-1:0]        cal_store_data,
   output logic [STAT_W-1:0]         quality_alarm_live,
   output logic [STAT_W-1:0]         quality_alarm_latched,
   output logic [STAT_W-1:0]         quality_alarm_mask,
   output logic [STAT_W-1:0]         operation_live,
   output logic [STAT_W-1:0]         operation_latched,
   output logic [STAT_W-1:0]         operation_mask,
   output logic                      quality_alarm_summary,
   output logic                      operation_summary,
   output logic                      service_request
);
   localparam logic [11:0] WAIT_MAX = `IRC_WAIT_MAX_S;
   localparam logic [31:0] SEC_CYC  = CLK_HZ;
   localparam logic [STAT_W-1:0] USED = STAT_W'(`IRC_STAT_USED_MASK);

   typedef struct packed {
      irc_panel_type             panel;
      logic                      disp_on;
      logic [8*`IRC_MSG_CHARS-1:0] msg;
      logic                      msg_shown;
      logic [2:0]                bright;
      irc_src_type               src;
      logic [11:0]               wait_s;
      logic [VAL_W-1:0]          tv;
      logic [VAL_W-1:0]          tc;
      irc_trig_type              trig;
      logic [11:0]               sec_left;
      logic [31:0]               cyc_left;
      logic [VAL_W-1:0]          ov;
      logic [VAL_W-1:0]          oc;
      logic                      apply;
      logic                      cal;
      logic [1:0]                kind;
      irc_cpt_type               vpt;
      logic [4*VAL_W-1:0]        cal_new;
      logic                      refused;
      logic                      store;
      logic [4*VAL_W-1:0]        store_data;
      logic [STAT_W-1:0]         qa_s1;
      logic [STAT_W-1:0]         qa_c;
      logic [STAT_W-1:0]         qa_prev;
      logic [STAT_W-1:0]         qa_e;
      logic [STAT_W-1:0]         qa_m;
      logic [STAT_W-1:0]         op_s1;
      logic [STAT_W-1:0]         op_c;
      logic [STAT_W-1:0]         op_prev;
      logic [STAT_W-1:0]         op_e;
      logic [STAT_W-1:0]         op_m;
   } irc_state_type;

   irc_state_type st_reg;
   irc_state_type st_next;

   always_comb begin
      st_next = st_reg;
      st_next.apply   = 1'b0;
      st_next.refused = 1'b0;
      st_next.store   = 1'b0;
      // panel mode
      if (go_local_cmd) begin
         st_next.panel   = IRC_LOCAL;              // [RULE_01]
         st_next.disp_on = 1'b1;                   // [RULE_06]
      end else if (remote_lockout_cmd) begin
         st_next.panel = IRC_LOCKOUT;              // [RULE_04]
      end else if (go_remote_cmd) begin
         st_next.panel = IRC_REMOTE;               // [RULE_02]
      end else if (panel_display_wr) begin
         st_next.disp_on = panel_display_val;      // [RULE_05]
      end
      if (panel_message_erase) begin
         st_next.msg_shown = 1'b0;                 // [RULE_07]
         st_next.msg       = '0;
      end else if (panel_message_wr) begin
         st_next.msg       = panel_message_val;    // [RULE_07]
         st_next.msg_shown = 1'b1;
      end
      if (panel_brightness_wr && panel_brightness_val <= `IRC_BRIGHT_MAX)
         st_next.bright = panel_brightness_val;    // [RULE_08]
      if (trig_origin_wr)
         st_next.src = trig_origin_imm ? IRC_SRC_IMM : IRC_SRC_BUS; // [RULE_09]
      if (trig_wait_wr) begin
         if (trig_wait_min)
            st_next.wait_s = `IRC_WAIT_MIN_S;      // [RULE_10]
         else if (trig_wait_max || trig_wait_val > WAIT_MAX)
            st_next.wait_s = WAIT_MAX;             // [RULE_10]
         else
            st_next.wait_s = trig_wait_val;
      end
      if (trig_level_wr) begin
         st_next.tv = trig_volt_val;
         st_next.tc = trig_curr_val;
      end
      // trigger sequencer
      case (st_reg.trig)
         IRC_IDLE: begin
            if (arm_trigger) begin
               if (st_reg.src == IRC_SRC_IMM) begin
                  st_next.ov    = st_reg.tv;       // [RULE_12]
                  st_next.oc    = st_reg.tc;
                  st_next.apply = 1'b1;
               end else begin
                  st_next.trig = IRC_ARMED;        // [RULE_13]
               end
            end
         end
         IRC_ARMED: begin
            if (bus_trigger) begin                 // [RULE_13]
               if (st_reg.wait_s == 12'h000) begin
                  st_next.ov    = st_reg.tv;
                  st_next.oc    = st_reg.tc;
                  st_next.apply = 1'b1;
                  st_next.trig  = IRC_IDLE;
               end else begin
                  st_next.sec_left = st_reg.wait_s; // [RULE_11]
                  st_next.cyc_left = SEC_CYC - 32'h1;
                  st_next.trig     = IRC_DELAY;
               end
            end
         end
         IRC_DELAY: begin
            if (st_reg.cyc_left != 32'h0) begin
               st_next.cyc_left = st_reg.cyc_left - 32'h1;
            end else if (st_reg.sec_left != 12'h001) begin
               st_next.sec_left = st_reg.sec_left - 12'h001;
               st_next.cyc_left = SEC_CYC - 32'h1;
            end else begin
               st_next.ov    = st_reg.tv;           // [RULE_11]
               st_next.oc    = st_reg.tc;
               st_next.apply = 1'b1;
               st_next.trig  = IRC_IDLE;
            end
         end
         default: st_next.trig = IRC_IDLE;
      endcase
      // calibration
      if (!st_reg.cal) begin
         if (cal_entry_key && cal_password == CAL_PASS) begin
            st_next.cal     = 1'b1;                // [RULE_15]
            st_next.vpt     = IRC_VMIN;
            st_next.cal_new = '0;
         end
         if (cal_kind_wr || cal_point_wr || overvoltage_auto_trim ||
             overcurrent_auto_trim || cal_commit_exit || cal_abort_exit)
            st_next.refused = 1'b1;                // [RULE_15]
      end else if (cal_commit_exit) begin
         st_next.cal        = 1'b0;                // [RULE_18]
         st_next.store      = 1'b1;
         st_next.store_data = st_reg.cal_new;
      end else if (cal_abort_exit) begin
         st_next.cal = 1'b0;                       // [RULE_18]
      end else if (cal_kind_wr) begin
         st_next.kind = cal_kind_val;              // [RULE_16]
         st_next.vpt  = IRC_VMIN;
      end else if (cal_point_wr) begin
         st_next.cal_new[st_reg.kind*VAL_W +: VAL_W] = cal_point_val;
         if (st_reg.kind == `IRC_CAL_VOLT) begin
            if (cal_point_sel == 2'(st_reg.vpt)) begin
               case (st_reg.vpt)
                  IRC_VMIN: st_next.vpt = IRC_VMID;
                  IRC_VMID: st_next.vpt = IRC_VMAX;
                  IRC_VMAX: begin
                     st_next.vpt  = IRC_VMIN;
                     st_next.kind = `IRC_CAL_OVP;  // [RULE_17]
                  end
                  default: st_next.vpt = IRC_VMIN;
               endcase
            end else begin
               st_next.vpt = IRC_VMIN;
            end
         end
      end else if (overvoltage_auto_trim) begin
         st_next.kind = `IRC_CAL_OVP;
      end else if (overcurrent_auto_trim) begin
         st_next.kind = `IRC_CAL_OCP;
      end
      // status groups
      st_next.qa_s1   = quality_alarm_cond_in;
      st_next.qa_c    = st_reg.qa_s1 & USED;       // [RULE_20]
      st_next.qa_prev = st_reg.qa_c;
      st_next.op_s1   = operation_cond_in;
      st_next.op_c    = st_reg.op_s1 & USED;       // [RULE_20]
      st_next.op_prev = st_reg.op_c;
      if (quality_alarm_latched_rd || clear_status_cmd)
         st_next.qa_e = '0;                        // [RULE_22]
      if (operation_latched_rd || clear_status_cmd)
         st_next.op_e = '0;                        // [RULE_22]
      // set wins over clear
      st_next.qa_e = st_next.qa_e | (st_reg.qa_c & ~st_reg.qa_prev); // [RULE_21] [RULE_25]
      st_next.op_e = st_next.op_e | (st_reg.op_c & ~st_reg.op_prev); // [RULE_21] [RULE_25]
      if (status_preset) begin
         st_next.qa_m = '0;
         st_next.op_m = '0;
      end else begin
         if (quality_alarm_mask_wr) st_next.qa_m = mask_wdata & USED;
         if (operation_mask_wr)     st_next.op_m = mask_wdata & USED;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_reg        <= '0;
         st_reg.panel  <= IRC_LOCAL;
         st_reg.disp_on <= 1'b1;
         st_reg.bright <= `IRC_BRIGHT_RST;
         st_reg.src    <= IRC_SRC_IMM;
         st_reg.trig   <= IRC_IDLE;
         st_reg.vpt    <= IRC_VMIN;
      end else begin
         st_reg <= st_next;
      end
   end

   assign panel_remote          = st_reg.panel != IRC_LOCAL;
   assign panel_knobs_en        = st_reg.panel == IRC_LOCAL;   // [RULE_02]
   assign panel_local_key_en    = st_reg.panel != IRC_LOCKOUT; // [RULE_04]
   assign panel_display_on      = st_reg.disp_on;
   assign annunciators_en       = st_reg.disp_on;              // [RULE_05]
   assign panel_message         = st_reg.msg;
   assign panel_message_shown   = st_reg.msg_shown;
   assign panel_brightness      = st_reg.bright;
   assign trig_origin_is_imm    = st_reg.src == IRC_SRC_IMM;
   assign trig_wait             = st_reg.wait_s;
   assign trig_armed            = st_reg.trig != IRC_IDLE;
   assign out_volt_level        = st_reg.ov;
   assign out_curr_level        = st_reg.oc;
   assign out_level_apply       = st_reg.apply;
   assign cal_mode              = st_reg.cal;
   assign cal_kind              = st_reg.kind;
   assign cal_cmd_refused       = st_reg.refused;
   assign cal_store             = st_reg.store;
   assign cal_store_data        = st_reg.store_data;
   assign quality_alarm_live    = st_reg.qa_c;                 // [RULE_19]
   assign quality_alarm_latched = st_reg.qa_e;
   assign quality_alarm_mask    = st_reg.qa_m;
   assign operation_live        = st_reg.op_c;
   assign operation_latched     = st_reg.op_e;
   assign operation_mask        = st_reg.op_m;
   assign quality_alarm_summary = |(st_reg.qa_e & st_reg.qa_m); // [RULE_24]
   assign operation_summary     = |(st_reg.op_e & st_reg.op_m); // [RULE_24]
   assign service_request = quality_alarm_summary | operation_summary; // [RULE_23]
endmodule

// File: rtl/irc_defines.svh
// constants for the instrument remote control block
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH
`define IRC_BRIGHT_MAX      3'h4
`define IRC_BRIGHT_RST      3'h4
`define IRC_WAIT_MAX_S      12'hE10
`define IRC_WAIT_MIN_S      12'h000
`define IRC_CLK_HZ          250000000
`define IRC_STAT_USED_MASK  16'h7FFF
`define IRC_CAL_VOLT        2'h0
`define IRC_CAL_OVP         2'h1
`define IRC_CAL_CURR        2'h2
`define IRC_CAL_OCP         2'h3
`define IRC_MSG_CHARS       16
`endif

// File: rtl/irc_pkg.sv
// types for the instrument remote control block
package irc_pkg;
   typedef enum logic [1:0] {IRC_LOCAL, IRC_REMOTE, IRC_LOCKOUT} irc_panel_type;
   typedef enum logic [1:0] {IRC_IDLE, IRC_ARMED, IRC_DELAY} irc_trig_type;
   typedef enum logic {IRC_SRC_BUS, IRC_SRC_IMM} irc_src_type;
   typedef enum logic [1:0] {IRC_VMIN, IRC_VMID, IRC_VMAX} irc_cpt_type;
endpackage

// File: tb/irc_chk.sv
// port-level assertions for the remote control block
module irc_chk
   import irc_pkg::*;
#(
   parameter int STAT_W = 16
) (
   input wire logic clk, nrst, go_local_cmd, go_remote_cmd,
   input wire logic remote_lockout_cmd, panel_remote, panel_knobs_en,
   input wire logic panel_local_key_en, panel_display_on, annunciators_en,
   input wire logic [2:0] panel_brightness,
   input wire logic [11:0] trig_wait,
   input wire logic trig_origin_wr, trig_origin_is_imm, arm_trigger,
   input wire logic bus_trigger, trig_armed, out_level_apply,
   input wire logic cal_point_wr, cal_entry_key, cal_mode, cal_cmd_refused,
   input wire logic [STAT_W-1:0] quality_alarm_live, quality_alarm_latched,
   input wire logic [STAT_W-1:0] quality_alarm_mask, quality_alarm_cond_in,
   input wire logic quality_alarm_latched_rd, clear_status_cmd,
   input wire logic quality_alarm_summary, operation_summary, service_request
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [STAT_W-1:0] live_d_reg;
   logic [STAT_W-1:0] rise;
   always_ff @(posedge clk) live_d_reg <= nrst ? quality_alarm_live : '0;
   assign rise = quality_alarm_live & ~live_d_reg;
   sequence s_bus_armed;
      trig_armed && !trig_origin_is_imm && trig_wait == 12'h000;
   endsequence
   sequence s_bus_hit;
      s_bus_armed ##0 bus_trigger;
   endsequence
   chk_local_panel: assert property (go_local_cmd |=> !panel_remote &&
      panel_knobs_en && panel_local_key_en && panel_display_on)
      else $error("local mode not entered");
   chk_remote_panel: assert property (go_remote_cmd && !go_local_cmd &&
      !remote_lockout_cmd |=> panel_remote && !panel_knobs_en &&
      panel_local_key_en) else $error("remote mode wrong");
   chk_lockout_keys: assert property (remote_lockout_cmd && !go_local_cmd
      |=> !panel_knobs_en && !panel_local_key_en)
      else $error("lockout left a key enabled");
   chk_blank_annun: assert property (!panel_display_on |-> !annunciators_en)
      else $error("annunciators lit with display off");
   chk_bright_range: assert property (panel_brightness <= 3'h4)
      else $error("brightness above top level");
   chk_wait_range: assert property (trig_wait <= 12'hE10)
      else $error("trigger wait above limit");
   chk_imm_apply: assert property (arm_trigger && trig_origin_is_imm &&
      !trig_origin_wr && !trig_armed |=> out_level_apply)
      else $error("arm did not apply");
   chk_bus_apply: assert property (s_bus_hit |=> out_level_apply &&
      !trig_armed) else $error("bus trigger did not apply");
   chk_cal_refuse: assert property (cal_point_wr && !cal_mode &&
      !cal_entry_key |=> cal_cmd_refused) else $error("cal not refused");
   chk_live_sync: assert property ($past(nrst) && $past(nrst, 2) &&
      $past(nrst, 3) |-> quality_alarm_live ==
      ($past(quality_alarm_cond_in, 2) & 16'h7FFF))
      else $error("live register not following input");
   chk_event_set: assert property (rise != '0 |=>
      (quality_alarm_latched & $past(rise)) == $past(rise))
      else $error("rising condition not latched");
   chk_event_hold: assert property ($past(nrst) &&
      !$past(quality_alarm_latched_rd) && !$past(clear_status_cmd) |->
      (quality_alarm_latched & $past(quality_alarm_latched)) ==
      $past(quality_alarm_latched)) else $error("event bit lost");
   chk_summary_or: assert property (quality_alarm_summary ==
      |(quality_alarm_latched & quality_alarm_mask))
      else $error("summary wrong");
   chk_service_req: assert property (quality_alarm_summary ||
      operation_summary |-> service_request) else $error("no service request");
endmodule

bind irc_remote_ctrl irc_chk #(.STAT_W(STAT_W)) i_irc_chk (.*);

// File: tb/irc_host.sv
// host-side model that issues one-clock command strobes
module irc_host (
   input wire logic clk
);
   timeunit 1ns;
   timeprecision 100ps;
   // strobe raised and dropped on falling edges, one sampling edge wide
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
endmodule

// File: tb/irc_remote_ctrl_tb.sv
// self-checking bench for the remote control block
`include "irc_defines.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
$display("unexpected %s exp %0h got %0h", n, e, a); end end
module irc_remote_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HZ = 10;
   localparam logic [15:0] PASS = 16'h1234;  // arbitrary value
   int bad_count = 0, checked = 0, cyc = 0, n;
   logic clk = 0, nrst = 0, go_local_cmd = 0, go_remote_cmd = 0;
   logic remote_lockout_cmd = 0, panel_display_wr = 0, panel_display_val = 0;
   logic panel_message_wr = 0, panel_message_erase = 0, trig_origin_wr = 0;
   logic panel_brightness_wr = 0, trig_origin_imm = 0, trig_wait_wr = 0;
   logic trig_wait_min = 0, trig_wait_max = 0, trig_level_wr = 0;
   logic arm_trigger = 0, bus_trigger = 0, cal_entry_key = 0, cal_kind_wr = 0;
   logic cal_point_wr = 0, overvoltage_auto_trim = 0, cal_commit_exit = 0;
   logic overcurrent_auto_trim = 0, cal_abort_exit = 0, status_preset = 0;
   logic quality_alarm_mask_wr = 0, operation_mask_wr = 0;
   logic quality_alarm_latched_rd = 0, operation_latched_rd = 0;
   logic clear_status_cmd = 0;
   logic [127:0] panel_message_val = '0, panel_message;
   logic [2:0] panel_brightness_val = '0, panel_brightness;
   logic [11:0] trig_wait_val = '0, trig_wait;
   logic [1:0] cal_kind_val = '0, cal_point_sel = '0, cal_kind;
   logic [15:0] trig_volt_val = '0, trig_curr_val = '0, cal_password = '0;
   logic [15:0] cal_point_val = '0, mask_wdata = '0, out_volt_level;
   logic [15:0] quality_alarm_cond_in = '0, operation_cond_in = '0;
   logic [15:0] out_curr_level, quality_alarm_live, quality_alarm_latched;
   logic [15:0] quality_alarm_mask, operation_live, operation_latched;
   logic [15:0] operation_mask;
   logic [63:0] cal_store_data;
   logic panel_remote, panel_knobs_en, panel_local_key_en, panel_display_on;
   logic annunciators_en, panel_message_shown, trig_origin_is_imm;
   logic trig_armed, out_level_apply, cal_mode, cal_cmd_refused, cal_store;
   logic quality_alarm_summary, operation_summary, service_request;

   irc_remote_ctrl #(.CLK_HZ(HZ), .CAL_PASS(PASS)) i_irc_remote_ctrl (.*);
   irc_host i_irc_host (.clk(clk));

   task automatic p(ref logic s);
      i_irc_host.pulse(s);
   endtask
   task automatic wsec(input logic [1:0] mm, input logic [11:0] v);
      trig_wait_max = mm[1];
      trig_wait_min = mm[0];
      trig_wait_val = v;
      p(trig_wait_wr);
   endtask
   task tk(input int k);
      repeat (k) @(negedge clk);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      tk(4);
      nrst = 1'b1;
      tk(1);
      `CHK("knobs", 1'b1, panel_knobs_en)
      `CHK("bright", `IRC_BRIGHT_RST, panel_brightness)
      `CHK("qmask", 16'h0000, quality_alarm_mask)
      $display("test reset done");
      p(go_remote_cmd);
      `CHK("knobs", 1'b0, panel_knobs_en)
      `CHK("key", 1'b1, panel_local_key_en)
      p(panel_display_wr);
      `CHK("annun", 1'b0, annunciators_en)
      p(remote_lockout_cmd);
      `CHK("key", 1'b0, panel_local_key_en)
      p(go_local_cmd);
      `CHK("key", 1'b1, panel_local_key_en)
      `CHK("disp", 1'b1, panel_display_on)
      panel_message_val = "ABCD";
      p(panel_message_wr);
      `CHK("msg", "ABCD", panel_message)
      p(panel_message_erase);
      `CHK("shown", 1'b0, panel_message_shown)
      for (int b = 0; b < 6; b++) begin
         panel_brightness_val = 3'(b);
         p(panel_brightness_wr);
         `CHK("bright", b > 4 ? 3'h4 : 3'(b), panel_brightness)
      end
      $display("test panel done");
      p(trig_origin_wr);
      `CHK("src", 1'b0, trig_origin_is_imm)
      wsec(2'b10, 12'h000);
      `CHK("wait", `IRC_WAIT_MAX_S, trig_wait)
      wsec(2'b01, 12'h000);
      `CHK("wait", `IRC_WAIT_MIN_S, trig_wait)
      wsec(2'b00, 12'hE11);
      `CHK("wait", `IRC_WAIT_MAX_S, trig_wait)
      wsec(2'b01, 12'hE10);
      `CHK("wait", `IRC_WAIT_MIN_S, trig_wait)
      trig_volt_val = 16'h1388;
      trig_curr_val = 16'h0BB8;
      p(trig_level_wr);
      p(arm_trigger);
      `CHK("apply", 1'b0, out_level_apply)
      p(bus_trigger);
      `CHK("volt", 16'h1388, out_volt_level)
      `CHK("curr", 16'h0BB8, out_curr_level)
      wsec(2'b00, 12'h002);
      p(arm_trigger);
      p(bus_trigger);
      n = 0;
      while (out_level_apply !== 1'b1 && n < 200) begin
         tk(1);
         n++;
      end
      `CHK("delay", 2 * HZ, n)
      trig_origin_imm = 1'b1;
      p(trig_origin_wr);
      p(arm_trigger);
      `CHK("apply", 1'b1, out_level_apply)
      $display("test trigger done");
      p(cal_point_wr);
      `CHK("refuse", 1'b1, cal_cmd_refused)
      cal_password = PASS ^ 16'h0001;
      p(cal_entry_key);
      `CHK("calmode", 1'b0, cal_mode)
      cal_password = PASS;
      p(cal_entry_key);
      `CHK("calmode", 1'b1, cal_mode)
      for (int k = 3; k >= 0; k--) begin
         cal_kind_val = 2'(k);
         p(cal_kind_wr);
         `CHK("kind", 2'(k), cal_kind)
      end
      for (int i = 0; i < 3; i++) begin
         cal_point_sel = 2'(i);
         cal_point_val = 16'h0100 + 16'(i);
         p(cal_point_wr);
      end
      `CHK("kind", `IRC_CAL_OVP, cal_kind)
      p(overvoltage_auto_trim);
      p(overcurrent_auto_trim);
      p(cal_commit_exit);
      `CHK("store", 1'b1, cal_store)
      `CHK("sdata", 16'h0102, cal_store_data[15:0])
      p(cal_entry_key);
      p(cal_abort_exit);
      `CHK("store", 1'b0, cal_store)
      `CHK("calmode", 1'b0, cal_mode)
      $display("test calibration done");
      mask_wdata = 16'hFFFF;
      p(quality_alarm_mask_wr);
      p(operation_mask_wr);
      `CHK("qmask", `IRC_STAT_USED_MASK, quality_alarm_mask)
      `CHK("omask", `IRC_STAT_USED_MASK, operation_mask)
      quality_alarm_cond_in = 16'h0001;
      operation_cond_in = 16'h0008;
      tk(1);
      quality_alarm_cond_in = 16'h0000;
      operation_cond_in = 16'h0000;
      tk(5);
      `CHK("qlat", 16'h0001, quality_alarm_latched)
      `CHK("olat", 16'h0008, operation_latched)
      `CHK("srq", 1'b1, service_request)
      quality_alarm_cond_in = 16'h0004;
      operation_cond_in = 16'h8010;
      tk(4);
      `CHK("qlive", 16'h0004, quality_alarm_live)
      `CHK("olive", 16'h0010, operation_live)
      p(quality_alarm_latched_rd);
      tk(3);
      `CHK("qlat", 16'h0000, quality_alarm_latched)
      p(status_preset);
      `CHK("osum", 1'b0, operation_summary)
      p(clear_status_cmd);
      `CHK("olat", 16'h0000, operation_latched)
      $display("test status done");
      stop_test();
   end
endmodule
